// >>> hdl/exception_mask_and_thread_control.sv
// exception mask registers, thread control register and execution state bits
//
// Operation
// - up to four conditional instructions per prefix
// - executes only in compact state; listed clears
// - execution with compact bit clear faults/locks
// - move and state-change instructions access masks
// - global mask blocks configurable-priority exceptions
// - fault mask blocks all but NMI
// - fault mask clears on non-NMI handler exit
// - nonzero threshold blocks configurable-priority value at/above
// - only upper threshold bits implemented
// - higher priority value means lower priority
// - control bit 2 shows float context active
// - control bit 1 selects process stack
// - handler mode forces main stack select
// - entry and return update control from code
// - reset uses main stack; switch by write/return
// - all exceptions except reset in handler mode
// - compact bit sits at status bit 24; the execution status read returns zero here
`default_nettype none
module exception_mask_and_thread_control #(
  parameter int  PRIO_BITS = 4,  // implemented threshold bits, from bit 7 down
  parameter bit  HAS_FLOAT = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  // special register move port
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [2:0]  regSel,
  input  wire logic [31:0] regWdata,
  output logic      [31:0] regRdata,
  // state-change instruction
  input  wire logic        cpsValid,
  input  wire logic        cpsDisable,
  input  wire logic        cpsCfg,
  input  wire logic        cpsFault,
  // exception entry and return
  input  wire logic        excEntry,
  input  wire logic [8:0]  excEntryNumber,
  input  wire logic        excEntryVecBit0,
  input  wire logic        resetVecLoad,
  input  wire logic        excReturn,
  input  wire logic [31:0] excReturnCode,
  input  wire logic        excReturnStackedT,
  input  wire logic [8:0]  excReturnNumber,
  // instruction stream events
  input  wire logic        instrExec,
  input  wire logic        interworkBranch,
  input  wire logic        interworkTarget0,
  input  wire logic        condPrefix,
  input  wire logic [3:0]  condPrefixLen,
  input  wire logic [3:0]  condPrefixFirst,
  input  wire logic [3:0]  condPrefixMask,
  input  wire logic        floatInstr,
  input  wire logic        floatLazyDone,
  // candidate exception for activation
  input  wire logic [7:0]  candPrio,
  input  wire logic        candConfig,
  input  wire logic        candIsNmi,
  output logic             candAllowed,
  // status outputs
  output logic [8:0]       activeNumber,
  output logic             handlerMode,
  output logic             useProcessStack,
  output logic             threadUnprivileged,
  output logic             floatContextActive,
  output logic             saveFloatOnEntry,
  output logic             compactState,
  output logic [3:0]       condRemaining,
  output logic [3:0]       condCode,
  output logic             usageFault,
  output logic             lockup
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic        cfgBlock_r, faultBlock_r;
  logic [7:0]  thresh_r;
  logic        floatCtx_r, stackSel_r, unpriv_r;
  logic        compact_r;
  logic [8:0]  active_r;
  logic [3:0]  condLeft_r, condFirst_r, condMask_r;
  excmask_pkg::exec_state_t exState_r, exState_nxt;
  logic [31:0] rdata_r;
  logic        allowed_r, saveFloat_r;
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  localparam logic [7:0] THR_KEEP = 8'(8'hff << (excmask_pkg::THRESH_W - PRIO_BITS));
  wire inHandler   = (active_r != excmask_pkg::THREAD_NUMBER);
  wire wrCfg       = regWrite & (regSel == excmask_pkg::SEL_CFG_BLOCK);
  wire wrFault     = regWrite & (regSel == excmask_pkg::SEL_FAULT_BLOCK);
  wire wrThresh    = regWrite & (regSel == excmask_pkg::SEL_THRESHOLD);
  wire wrCtrl      = regWrite & (regSel == excmask_pkg::SEL_THREAD_CTRL);
  wire cpsCfgHit   = cpsValid & cpsCfg;
  wire cpsFltHit   = cpsValid & cpsFault;
  wire retNonNmi   = excReturn & (active_r != excmask_pkg::NMI_NUMBER);
  wire retThread   = excReturnCode[excmask_pkg::RET_MODE_BIT];
  wire retProcess  = excReturnCode[excmask_pkg::RET_STACK_SELECT_BIT];
  wire retFloat    = ~excReturnCode[excmask_pkg::RET_FRAME_BIT];
  wire badExec     = instrExec & ~compact_r;
  // ------------------------------------------------------------
  // activation gate
  // ------------------------------------------------------------
  prio_gate_if gif ();
  assign gif.reqPrio    = candPrio;
  assign gif.reqConfig  = candConfig;
  assign gif.reqIsNmi   = candIsNmi;
  assign gif.cfgBlock   = cfgBlock_r;
  assign gif.faultBlock = faultBlock_r;
  assign gif.threshold  = thresh_r;
  prio_gate uGate (
    .g (gif.gate)
  );
  // ------------------------------------------------------------
  // read mux, reserved bits zero
  // ------------------------------------------------------------
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    case (regSel)
      excmask_pkg::SEL_CFG_BLOCK:   rdMux[excmask_pkg::MASK_BIT] = cfgBlock_r;
      excmask_pkg::SEL_FAULT_BLOCK: rdMux[excmask_pkg::MASK_BIT] = faultBlock_r;
      excmask_pkg::SEL_THRESHOLD:   rdMux[7:0]                   = thresh_r;
      excmask_pkg::SEL_THREAD_CTRL: begin
        rdMux[excmask_pkg::CTRL_FLOAT_CONTEXT_ACTIVE_BIT] = floatCtx_r;
        rdMux[excmask_pkg::CTRL_SSEL_BIT] = stackSel_r & ~inHandler;
        rdMux[excmask_pkg::CTRL_NPRV_BIT] = unpriv_r;
      end
      default:         rdMux = 32'h0;  // execution status reads zero to software
    endcase
  end
  // ------------------------------------------------------------
  // mask registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfgBlock_r <= 1'b0;
    end else if (cpsCfgHit) begin
      cfgBlock_r <= cpsDisable;
    end else if (wrCfg) begin
      cfgBlock_r <= regWdata[excmask_pkg::MASK_BIT];
    end
  end

  // fault mask: hardware clear on handler exit wins over a late write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      faultBlock_r <= 1'b0;
    end else if (retNonNmi) begin
      faultBlock_r <= 1'b0;
    end else if (cpsFltHit) begin
      faultBlock_r <= cpsDisable;
    end else if (wrFault) begin
      faultBlock_r <= regWdata[excmask_pkg::MASK_BIT];
    end
  end

  // threshold keeps only the implemented high bits
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      thresh_r <= excmask_pkg::THRESH_OFF;
    end else if (wrThresh) begin
      thresh_r <= regWdata[7:0] & THR_KEEP;
    end
  end
  // ------------------------------------------------------------
  // thread control register and mode tracking
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stackSel_r <= excmask_pkg::CTRL_RESET[excmask_pkg::CTRL_SSEL_BIT];
      unpriv_r   <= excmask_pkg::CTRL_RESET[excmask_pkg::CTRL_NPRV_BIT];
      active_r   <= excmask_pkg::THREAD_NUMBER;
    end else if (excEntry) begin
      stackSel_r <= 1'b0;
      active_r   <= excEntryNumber;
    end else if (excReturn) begin
      stackSel_r <= retThread & retProcess;
      active_r   <= retThread ? excmask_pkg::THREAD_NUMBER : excReturnNumber;
    end else if (wrCtrl) begin
      if (!inHandler) begin
        stackSel_r <= regWdata[excmask_pkg::CTRL_SSEL_BIT];
      end
      unpriv_r <= regWdata[excmask_pkg::CTRL_NPRV_BIT];
    end
  end

  // float context: set by float use, cleared on entry, restored on return
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      floatCtx_r  <= excmask_pkg::CTRL_RESET[excmask_pkg::CTRL_FLOAT_CONTEXT_ACTIVE_BIT];
      saveFloat_r <= 1'b0;
    end else begin
      // lazy-save done clears first so a same-cycle entry latch wins
      if (floatLazyDone) begin
        saveFloat_r <= 1'b0;
      end
      if (excEntry) begin
        saveFloat_r <= floatCtx_r & HAS_FLOAT;
        floatCtx_r  <= 1'b0;
      end else if (excReturn) begin
        floatCtx_r <= retFloat & HAS_FLOAT;
      end else if (wrCtrl) begin
        floatCtx_r <= regWdata[excmask_pkg::CTRL_FLOAT_CONTEXT_ACTIVE_BIT] & HAS_FLOAT;
      end else if (floatInstr) begin
        floatCtx_r <= HAS_FLOAT;
      end
    end
  end
  // ------------------------------------------------------------
  // compact state bit
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      compact_r <= 1'b1;
    end else if (resetVecLoad | excEntry) begin
      compact_r <= excEntryVecBit0;
    end else if (excReturn) begin
      compact_r <= excReturnStackedT;
    end else if (interworkBranch) begin
      compact_r <= interworkTarget0;
    end
  end
  // ------------------------------------------------------------
  // conditional block tracking
  // ------------------------------------------------------------
  wire [3:0] prefixLen = (condPrefixLen > excmask_pkg::COND_MAX) ? excmask_pkg::COND_MAX : condPrefixLen;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      condLeft_r  <= 4'h0;
      condFirst_r <= 4'h0;
      condMask_r  <= 4'h0;
    end else if (excEntry) begin
      condLeft_r <= 4'h0;
    end else if (condPrefix & compact_r) begin
      condLeft_r  <= prefixLen;
      condFirst_r <= condPrefixFirst;
      condMask_r  <= condPrefixMask;
    end else if (instrExec & compact_r & (condLeft_r != 4'h0)) begin
      condLeft_r <= condLeft_r - 4'h1;
      condMask_r <= {condMask_r[2:0], 1'b0};
    end
  end
  // each slot uses base condition or its inverse (low bit flipped)
  wire [3:0] curCond = {condFirst_r[3:1], condFirst_r[0] ^ condMask_r[3]};
  // ------------------------------------------------------------
  // execution state: fault, lockup if faulting in a handler numbered 1 to 3
  // ------------------------------------------------------------
  always_comb begin
    exState_nxt = exState_r;
    case (exState_r)
      excmask_pkg::EX_RUN: begin
        if (badExec) begin
          exState_nxt = ((active_r <= 9'h003) && inHandler) ? excmask_pkg::EX_LOCKUP : excmask_pkg::EX_FAULT;
        end
      end
      excmask_pkg::EX_FAULT:  exState_nxt = excmask_pkg::EX_RUN;
      excmask_pkg::EX_LOCKUP: exState_nxt = excmask_pkg::EX_LOCKUP;
      default:                exState_nxt = excmask_pkg::EX_RUN;
    endcase
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      exState_r <= excmask_pkg::EX_RUN;
    end else begin
      exState_r <= exState_nxt;
    end
  end
  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_r   <= 32'h0;
      allowed_r <= 1'b0;
    end else begin
      rdata_r   <= regRead ? rdMux : 32'h0;
      allowed_r <= gif.allowed;
    end
  end
  assign regRdata           = rdata_r;
  assign candAllowed        = allowed_r;
  assign activeNumber       = active_r;
  assign handlerMode        = inHandler;
  assign useProcessStack    = stackSel_r;
  assign threadUnprivileged = unpriv_r;
  assign floatContextActive = floatCtx_r;
  assign saveFloatOnEntry   = saveFloat_r;
  assign compactState       = compact_r;
  assign condRemaining      = condLeft_r;
  assign condCode           = curCond;
  assign usageFault         = (exState_r == excmask_pkg::EX_FAULT);
  assign lockup             = (exState_r == excmask_pkg::EX_LOCKUP);
endmodule : exception_mask_and_thread_control
`default_nettype wire

// >>> hdl/prio_gate.sv
// combinational activation gate from the mask registers
`default_nettype none
module prio_gate (
  prio_gate_if.gate g
);
  // ------------------------------------------------------------
  // gating terms
  // ------------------------------------------------------------
  // lower value means higher priority
  wire thrBlocks = (g.threshold != excmask_pkg::THRESH_OFF) && (g.reqPrio >= g.threshold);
  wire cfgBlocks = g.cfgBlock & g.reqConfig & ~g.reqIsNmi;
  wire fltBlocks = g.faultBlock & ~g.reqIsNmi;
  assign g.allowed = ~(cfgBlocks | fltBlocks | (thrBlocks & g.reqConfig & ~g.reqIsNmi));
endmodule : prio_gate
`default_nettype wire

// >>> pkg/excmask_pkg.sv
// package of constants and types for the exception mask and thread control block
`default_nettype none
package excmask_pkg;
  // ------------------------------------------------------------
  // special register selectors on the move port
  // ------------------------------------------------------------
  localparam logic [2:0] SEL_CFG_BLOCK   = 3'h0;
  localparam logic [2:0] SEL_FAULT_BLOCK = 3'h1;
  localparam logic [2:0] SEL_THRESHOLD   = 3'h2;
  localparam logic [2:0] SEL_THREAD_CTRL = 3'h3;
  localparam logic [2:0] SEL_EXEC_STATUS = 3'h4;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int MASK_BIT      = 0;
  localparam int CTRL_FLOAT_CONTEXT_ACTIVE_BIT = 2;
  localparam int CTRL_SSEL_BIT = 1;
  localparam int CTRL_NPRV_BIT = 0;
  localparam int COMPACT_BIT   = 24;
  localparam int THRESH_W      = 8;
  localparam logic [7:0] THRESH_OFF    = 8'h00;
  localparam logic [2:0] CTRL_RESET    = 3'h0;
  localparam logic [3:0] COND_MAX      = 4'h4;
  localparam logic [8:0] NMI_NUMBER    = 9'h002;
  localparam logic [8:0] THREAD_NUMBER = 9'h000;
  // exception return code: bit 2 picks process stack, bit 3 thread return, bit 4 clear = float frame
  localparam int RET_STACK_SELECT_BIT = 2;
  localparam int RET_MODE_BIT  = 3;
  localparam int RET_FRAME_BIT = 4;
  // ------------------------------------------------------------
  // execution state machine
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    EX_RUN    = 2'b00,
    EX_FAULT  = 2'b01,
    EX_LOCKUP = 2'b11
  } exec_state_t;
endpackage : excmask_pkg
`default_nettype wire

// >>> pkg/prio_gate_if.sv
// interface carrying a priority request and its gating answer
`default_nettype none
interface prio_gate_if;
  logic [7:0] reqPrio;
  logic       reqConfig;
  logic       reqIsNmi;
  logic       cfgBlock;
  logic       faultBlock;
  logic [7:0] threshold;
  logic       allowed;
  modport gate (input reqPrio, reqConfig, reqIsNmi, cfgBlock, faultBlock, threshold, output allowed);
  modport user (output reqPrio, reqConfig, reqIsNmi, cfgBlock, faultBlock, threshold, input allowed);
endinterface : prio_gate_if
`default_nettype wire

// >>> sim/exception_mask_and_thread_control_checker.sv
// checker of mask, control and execution state behaviour at the block's ports
`default_nettype none
module exception_mask_and_thread_control_checker #(
  parameter int PRIO_BITS = 4
) (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [2:0]  regSel,
  input wire logic [31:0] regWdata,
  input wire logic [31:0] regRdata,
  input wire logic        excEntry,
  input wire logic [8:0]  excEntryNumber,
  input wire logic        excReturn,
  input wire logic [31:0] excReturnCode,
  input wire logic        instrExec,
  input wire logic [8:0]  activeNumber,
  input wire logic        handlerMode,
  input wire logic        useProcessStack,
  input wire logic        compactState,
  input wire logic        usageFault,
  input wire logic        lockup
);
  // ----------------------------------------
  // helper values
  // ----------------------------------------
  localparam logic [2:0] SELT = excmask_pkg::SEL_THRESHOLD;
  localparam logic [2:0] SELC = excmask_pkg::SEL_THREAD_CTRL;
  // threshold bits that may read non-zero
  wire logic [31:0] keepMask = 32'h000000ff & (32'hffffffff << (8 - PRIO_BITS));
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_cfg_rsv; regRead && regSel == 3'h0 |=> regRdata[31:1] == 31'h0; endproperty
  property p_thr_bits; regRead && regSel == SELT |=> (regRdata & ~keepMask) == 32'h0; endproperty
  property p_hnd_ssel; handlerMode && regRead && regSel == SELC |=> !regRdata[1]; endproperty
  property p_bad_state; instrExec && !compactState |-> ##[0:1] (usageFault || lockup); endproperty
  property p_lock_hold; lockup |=> lockup; endproperty
  property p_ctrl_wr;
    regWrite && regSel == SELC && !handlerMode && !excEntry && !excReturn |=> useProcessStack == $past(regWdata[1]);
  endproperty
  property p_ret_thr;
    excReturn && excReturnCode[excmask_pkg::RET_MODE_BIT] && !excEntry && !regWrite
      |=> useProcessStack == $past(excReturnCode[2]);
  endproperty
  property p_entry; excEntry && excEntryNumber != 9'h0 |=> handlerMode && activeNumber == $past(excEntryNumber); endproperty
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("global mask reserved bits not zero");
  a_thr_bits: assert property (p_thr_bits) else $error("threshold low bits not zero");
  a_hnd_ssel: assert property (p_hnd_ssel) else $error("stack select reads one in handler");
  a_bad_state: assert property (p_bad_state) else $error("no fault on execution outside compact state");
  a_lock_hold: assert property (p_lock_hold) else $error("lockup released");
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("stack select not written");
  a_ret_thr: assert property (p_ret_thr) else $error("stack select not taken from return code");
  a_entry: assert property (p_entry) else $error("entry did not enter handler mode");
  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_lockup: cover property ($rose(lockup));
  c_fault: cover property ($rose(usageFault));
  c_ret_thr: cover property (excReturn && excReturnCode[3]);
endmodule : exception_mask_and_thread_control_checker
bind exception_mask_and_thread_control exception_mask_and_thread_control_checker #(.PRIO_BITS(PRIO_BITS)) chk_i (
  .clock, .nrst, .regWrite, .regRead, .regSel, .regWdata, .regRdata, .excEntry, .excEntryNumber, .excReturn,
  .excReturnCode, .instrExec, .activeNumber, .handlerMode, .useProcessStack, .compactState, .usageFault, .lockup);
`default_nettype wire

// >>> sim/exception_mask_and_thread_control_tb.sv
// self-checking bench for the exception mask and thread control block
`default_nettype none
module exception_mask_and_thread_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  localparam int PB = 4;
  localparam logic [7:0] TMASK = 8'hff << (8 - PB);
  logic clock = 0, nrst = 0, regWrite = 0, regRead = 0, cpsValid = 0, cpsDisable = 0, cpsCfg = 0, cpsFault = 0;
  logic excEntry = 0, excEntryVecBit0 = 0, resetVecLoad = 0, excReturn = 0, excReturnStackedT = 1, instrExec = 0;
  logic interworkBranch = 0, interworkTarget0 = 1, condPrefix = 0, floatInstr = 0, floatLazyDone = 0;
  logic candConfig = 0, candIsNmi = 0, candAllowed, handlerMode, useProcessStack, threadUnprivileged;
  logic floatContextActive, saveFloatOnEntry, compactState, usageFault, lockup;
  logic [2:0] regSel = 0, s, ctl = 0;
  logic [31:0] regWdata = 0, excReturnCode = 0, regRdata, r, d;
  logic [8:0] excEntryNumber = 0, excReturnNumber = 0, activeNumber;
  logic [3:0] condPrefixLen = 0, condPrefixFirst = 0, condPrefixMask = 0, condRemaining, condCode;
  logic [7:0] candPrio = 0, thr = 0;
  logic cfgM = 0, fltM = 0, hnd = 0;
  int seed = 3085, fail_count = 0, total_checks = 0, i;
  exception_mask_and_thread_control #(.PRIO_BITS(PB), .HAS_FLOAT(1'b1)) exception_mask_and_thread_control_i (
    .clock, .nrst, .regWrite, .regRead, .regSel, .regWdata, .regRdata, .cpsValid, .cpsDisable, .cpsCfg, .cpsFault,
    .excEntry, .excEntryNumber, .excEntryVecBit0, .resetVecLoad, .excReturn, .excReturnCode, .excReturnStackedT,
    .excReturnNumber, .instrExec, .interworkBranch, .interworkTarget0, .condPrefix, .condPrefixLen,
    .condPrefixFirst, .condPrefixMask, .floatInstr, .floatLazyDone, .candPrio, .candConfig, .candIsNmi,
    .candAllowed, .activeNumber, .handlerMode, .useProcessStack, .threadUnprivileged, .floatContextActive,
    .saveFloatOnEntry, .compactState, .condRemaining, .condCode, .usageFault, .lockup);
  always #4 clock = ~clock;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] want(input logic [2:0] sel);
    case (sel)
      3'h0: want = {31'h0, cfgM};
      3'h1: want = {31'h0, fltM};
      3'h2: want = {24'h0, thr};
      3'h3: want = {29'h0, ctl[2], ctl[1] & !hnd, ctl[0]};
      default: want = 32'h0;
    endcase
  endfunction : want
  task automatic wr(input logic [2:0] sel, input logic [31:0] v);
    @(posedge clock);
    regWrite <= 1'b1;
    regSel <= sel;
    regWdata <= v;
    @(posedge clock);
    regWrite <= 1'b0;
    if (sel == 3'h0) cfgM = v[0];
    if (sel == 3'h1) fltM = v[0];
    if (sel == 3'h2) thr = v[7:0] & TMASK;
    if (sel == 3'h3) ctl = {v[2], hnd ? ctl[1] : v[1], v[0]};
  endtask : wr
  task automatic rd(input logic [2:0] sel);
    @(posedge clock);
    regRead <= 1'b1;
    regSel <= sel;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdata, want(sel), "register read");
  endtask : rd
  task automatic cand(input logic [7:0] p, input logic c, input logic n);
    @(posedge clock);
    candPrio <= p;
    candConfig <= c;
    candIsNmi <= n;
    @(posedge clock);
    #1 chk(candAllowed, n || !(fltM || c && (cfgM || thr != 0 && p >= thr)), "activation gate");
  endtask : cand
  task automatic ev(input int k);
    @(posedge clock);
    case (k)
      0: floatInstr <= 1'b1;
      1: floatLazyDone <= 1'b1;
      2: cpsValid <= 1'b1;
      3: interworkBranch <= 1'b1;
      4: instrExec <= 1'b1;
      5: condPrefix <= 1'b1;
      default: resetVecLoad <= 1'b1;
    endcase
    @(posedge clock);
    {floatInstr, floatLazyDone, cpsValid, interworkBranch, instrExec, condPrefix, resetVecLoad} <= 7'h0;
    #1;
  endtask : ev
  task automatic entry(input logic [8:0] n);
    @(posedge clock);
    excEntry <= 1'b1;
    excEntryNumber <= n;
    @(posedge clock);
    excEntry <= 1'b0;
    hnd = 1'b1;
    ctl = {2'b00, ctl[0]};
    #1 chk(handlerMode, 1'b1, "handler mode on entry");
    chk(activeNumber, n, "active number on entry");
  endtask : entry
  task automatic ret(input logic [31:0] c, input logic [8:0] from);
    @(posedge clock);
    excReturn <= 1'b1;
    excReturnCode <= c;
    @(posedge clock);
    excReturn <= 1'b0;
    if (from != excmask_pkg::NMI_NUMBER) fltM = 1'b0;
    hnd = !c[3];
    ctl = {!c[4], c[3] & c[2], ctl[0]};
  endtask : ret
  task automatic waitfor(ref logic sig, input string what);
    for (i = 0; i < 4 && sig !== 1'b1; i++) @(posedge clock) #1;
    chk(sig, 1'b1, what);
  endtask : waitfor
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    #1 chk(compactState, 1'b1, "compact state after reset");
    for (int k = 0; k < 5; k++) rd(k[2:0]);
    $display("done: reset values");
    repeat (16) begin
      r = $random(seed);
      d = $random(seed);
      s = {1'b0, r[1:0]};
      wr(s, d);
      rd(s);
      cand(r[15:8] & TMASK, r[16], r[17] & r[18]);
    end
    wr(3'h0, 32'h0);
    wr(3'h1, 32'h0);
    wr(3'h2, 32'h45);
    cand(8'h40, 1'b1, 1'b0);
    cand(8'h30, 1'b1, 1'b0);
    $display("done: register moves and gating");
    for (int k = 0; k < 8; k++) begin
      {cpsDisable, cpsCfg, cpsFault} <= k[2:0];
      ev(2);
      if (k[1]) cfgM = k[2];
      if (k[0]) fltM = k[2];
      rd(3'h0);
      rd(3'h1);
      cand(8'hf0, 1'b0, 1'b0);
      cand(8'h00, 1'b0, 1'b1);
    end
    $display("done: state-change instruction");
    wr(3'h1, 32'h1);
    wr(3'h3, 32'h3);
    @(posedge clock);
    #1 chk(threadUnprivileged, 1'b1, "thread privilege");
    entry(9'h00b);
    chk(useProcessStack, 1'b0, "handler stack");
    wr(3'h3, 32'h2);
    rd(3'h3);
    ret(32'hfffffffd, 9'h00b);
    rd(3'h1);
    rd(3'h3);
    wr(3'h1, 32'h1);
    entry(excmask_pkg::NMI_NUMBER);
    ret(32'hfffffff9, excmask_pkg::NMI_NUMBER);
    rd(3'h1);
    $display("done: handler entry and return");
    ev(0);
    chk(floatContextActive, 1'b1, "float context set by float use");
    ctl[2] = 1'b1;
    rd(3'h3);
    entry(9'h00f);
    chk(saveFloatOnEntry, 1'b1, "float save on entry");
    ev(1);
    chk(saveFloatOnEntry, 1'b0, "lazy save done");
    ret(32'hfffffff9, 9'h00f);
    $display("done: float context");
    condPrefixLen <= 4'h6;
    condPrefixFirst <= 4'ha;
    condPrefixMask <= 4'h4;
    ev(5);
    chk(condRemaining, 4'h4, "conditional length clamped");
    chk(condCode, 4'ha, "first condition");
    ev(4);
    chk(condCode, 4'hb, "inverse condition in second slot");
    chk(condRemaining, 4'h3, "conditional count after one");
    repeat (3) ev(4);
    chk(condRemaining, 4'h0, "conditional block over");
    $display("done: conditional block");
    interworkTarget0 <= 1'b0;
    ev(3);
    chk(compactState, 1'b0, "compact bit cleared");
    ev(4);
    waitfor(usageFault, "fault outside compact state");
    excEntryVecBit0 <= 1'b1;
    ev(6);
    chk(compactState, 1'b1, "compact bit from vector");
    entry(9'h003);
    ev(3);
    ev(4);
    waitfor(lockup, "lockup in fault handler");
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    #1 chk(lockup, 1'b0, "lockup cleared by reset");
    chk(compactState, 1'b1, "compact state after second reset");
    chk(useProcessStack, 1'b0, "main stack after second reset");
    chk(handlerMode, 1'b0, "thread mode after second reset");
    $display("done: compact state");
    summarize();
  end
endmodule : exception_mask_and_thread_control_tb
`default_nettype wire
